/* tbc_trace_buffer_controller.v */
// trace buffer controller: apb register file, architectural state machine,
// local trace memory feeding an atb drain, axi write master and stream out.
// assumes the atb source, axi slave and stream sink follow their protocols.
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "tbc_map.vh"

// How it works
// - atb drain output only active in the sram fifo configuration
// - axi writes limited to 32 in flight, reads never issued
// - any axi error response halts memory writes until software clears it
// - buffer size register is 31 bits wide, largest value selects 256MB
// - low axi address bits tied to zero for data-width alignment
// - stream output carries data bytes only, never position or null bytes
// - two event inputs and three event outputs in every configuration
// - in system-memory and stream configurations, buffer interrupt high while fill level is at or above watermark
// - authentication input honoured only in system-memory configuration
// - test clock gate override keeps the internal clock enable open
// - disabled after reset and when capture is cleared; programming here
// - capture enable moves disabled to running; stop event to stopping
// - stopping drains pipelines and reads back like running
// - stopped reached only once atb input, axi and stream idle; fifo empty in system-memory, stream or hard fifo mode
// - soft fifo modes need room in fifo before reaching stopped
// - drain request in stopped circular sram fifo starts a drain
// - draining sends buffer out over atb then returns to stopped
// - clearing capture enters disabling then disabled once axi and stream are idle
// - no trace word is written to the fifo while disabling
// - memory error while disabling ends writes and goes to disabled
// - disabling waits while an axi or stream transfer is stalled
// - single clock, active-low reset initialising control state
module tbc_trace_buffer_controller (
   // apb
   input  wire        pclk,
   input  wire        presetn,
   input  wire        clk_en,
   input  wire        dft_cg_en,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // atb trace input
   input  wire        atb_valid,
   input  wire [31:0] atb_data,
   output reg         atb_ready,
   // atb drain output
   output reg         drain_valid,
   output reg  [31:0] drain_data,
   input  wire        drain_ready,
   // axi write master
   output reg         awvalid,
   output reg  [31:0] awaddr,
   input  wire        awready,
   output reg         wvalid,
   output reg  [31:0] wdata,
   input  wire        wready,
   input  wire        bvalid,
   input  wire [1:0]  bresp,
   output reg         bready,
   output reg         arvalid,
   output reg  [31:0] araddr,
   // stream output
   output reg         tvalid,
   output reg  [31:0] tdata,
   output reg  [3:0]  tkeep,
   input  wire        tready,
   // events, interrupt, authentication
   input  wire [1:0]  event_in,
   output reg  [2:0]  event_out,
   output reg         buffer_irq,
   input  wire        auth_enable
);

////////////////////////////////////////////////////////////////////////////
localparam [2:0] ST_DISABLED  = 3'h0;
localparam [2:0] ST_RUNNING   = 3'h1;
localparam [2:0] ST_STOPPING  = 3'h2;
localparam [2:0] ST_STOPPED   = 3'h3;
localparam [2:0] ST_DRAINING  = 3'h4;
localparam [2:0] ST_DISABLING = 3'h5;

reg  [2:0]                    state_r;
reg  [2:0]                    state_nxt;
reg                           capture_enable_r;
reg  [1:0]                    cfg_r;
reg  [1:0]                    mode_r;
reg  [30:0]                   buffer_size_r;
reg  [31:0]                   base_r;
reg  [`TBC_LEVEL_BITS-1:0]    watermark_r;
reg                           stop_on_flush_r;
reg                           manual_flush_r;
reg                           drain_request_r;
reg                           memory_error_flag_r;
reg                           full_r;
reg  [31:0]                   mem_r [0:`TBC_MEM_DEPTH-1];
reg  [`TBC_PTR_BITS-1:0]      wptr_r;
reg  [`TBC_PTR_BITS-1:0]      rptr_r;
reg  [`TBC_LEVEL_BITS-1:0]    level_r;
reg  [5:0]                    outstanding_r;
reg  [31:0]                   wr_offset_r;
reg  [1:0]                    event_in_d_r;

wire gclk_en = clk_en | dft_cg_en;
wire apb_wr  = psel & penable & pwrite & ~pready;
wire apb_rd  = psel & penable & ~pwrite & ~pready;
wire empty   = (level_r == {`TBC_LEVEL_BITS{1'b0}});
wire is_full = (level_r == `TBC_LEVEL_FULL);
wire fifo_md = (mode_r != `TBC_MODE_CIRCULAR);
wire sysmem  = (cfg_r == `TBC_CFG_SYSTEM_MEMORY);
wire stream  = (cfg_r == `TBC_CFG_STREAM_OUT);
wire sfifo   = (cfg_r == `TBC_CFG_SRAM_FIFO);
wire authorised = ~sysmem | auth_enable;
wire capturing  = (state_r == ST_RUNNING) | (state_r == ST_STOPPING);
wire stop_event = (stop_on_flush_r & manual_flush_r) | event_in_d_r[1];
wire [31:0] head = mem_r[rptr_r];

// address decode shared by reads and writes
function is_reg;
   input [11:0] a;
   input [11:0] off;
   begin
      is_reg = (a == off);
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// drain side selection per configuration
wire axi_go  = sysmem & ~memory_error_flag_r & ~empty &
               (outstanding_r < `TBC_MAX_OUTSTANDING) &
               ~awvalid & ~wvalid;
wire axi_done_aw = awvalid & awready;
wire axi_done_w  = wvalid & wready;
wire str_go  = stream & ~empty & ~tvalid;
wire drn_go  = sfifo & (state_r == ST_DRAINING) & ~empty & ~drain_valid;
wire hw_go   = sfifo & (mode_r == `TBC_MODE_HARD_FIFO) & capturing &
               ~empty & ~drain_valid;
wire pop_any = axi_go | str_go | drn_go | hw_go;
wire apb_pop = apb_rd & is_reg(paddr, `TBC_READ_DATA_REG) & ~empty;
wire in_busy = awvalid | wvalid | tvalid | (outstanding_r != 6'h00);
// fifo modes refuse new input when full; circular mode overwrites the oldest word
wire push    = capturing & atb_valid & atb_ready & authorised;
wire pop     = pop_any | apb_pop;
wire ovr     = push & is_full & ~pop;

////////////////////////////////////////////////////////////////////////////
// architectural state machine
always @* begin
   state_nxt = state_r;
   case (state_r)
      ST_DISABLED: begin
         if (capture_enable_r)
            state_nxt = ST_RUNNING;
      end
      ST_RUNNING: begin
         if (!capture_enable_r)
            state_nxt = ST_DISABLING;
         else if (stop_event)
            state_nxt = ST_STOPPING;
      end
      ST_STOPPING: begin
         // every word must reach memory or stream; hard fifo must empty
         if (!capture_enable_r)
            state_nxt = ST_DISABLING;
         else if (!in_busy && !atb_valid && (empty || !(sysmem | stream)) &&
                  (!(mode_r == `TBC_MODE_HARD_FIFO) || empty) &&
                  (!(mode_r == `TBC_MODE_SOFT_APB ||
                     mode_r == `TBC_MODE_SOFT_DIRECT) || !is_full))
            state_nxt = ST_STOPPED;
      end
      ST_STOPPED: begin
         if (!capture_enable_r)
            state_nxt = ST_DISABLING;
         else if (drain_request_r && sfifo && !fifo_md)
            state_nxt = ST_DRAINING;
      end
      ST_DRAINING: begin
         if (!capture_enable_r)
            state_nxt = ST_DISABLING;
         else if (empty && !drain_valid)
            state_nxt = ST_STOPPED;
      end
      ST_DISABLING: begin
         // started axi or stream beats cannot be aborted
         if (memory_error_flag_r || !in_busy)
            state_nxt = ST_DISABLED;
      end
      default: state_nxt = ST_DISABLED;
   endcase
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn)
      state_r <= ST_DISABLED;
   else if (gclk_en)
      state_r <= state_nxt;
end

////////////////////////////////////////////////////////////////////////////
// apb slave, access phase with one wait state
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      prdata           <= `TBC_ZERO32;
      capture_enable_r <= 1'b0;
      cfg_r            <= `TBC_CFG_SRAM_BUFFER;
      mode_r           <= `TBC_MODE_CIRCULAR;
      buffer_size_r    <= `TBC_BUFFER_SIZE_RST;
      base_r           <= `TBC_ZERO32;
      watermark_r      <= {`TBC_LEVEL_BITS{1'b0}};
      stop_on_flush_r  <= 1'b0;
      manual_flush_r   <= 1'b0;
      drain_request_r  <= 1'b0;
   end else if (gclk_en) begin
      pready  <= psel & penable & ~pready;
      pslverr <= 1'b0;
      if (state_r == ST_STOPPING && state_nxt == ST_STOPPED)
         manual_flush_r <= 1'b0;
      if (state_r == ST_DRAINING)
         drain_request_r <= 1'b0;
      if (apb_wr) begin
         // setup registers only take writes while disabled
         if (is_reg(paddr, `TBC_CTL_REG))
            capture_enable_r <= pwdata[`TBC_CTL_CAPTURE_EN];
         else if (is_reg(paddr, `TBC_FLUSH_CONTROL_REG)) begin
            stop_on_flush_r <= pwdata[`TBC_FLUSH_CONTROL_REG_STOP_ON_FL];
            manual_flush_r  <= (manual_flush_r & (state_nxt != ST_STOPPED)) |
                               pwdata[`TBC_FLUSH_CONTROL_REG_MANUAL_FLUSH];
            drain_request_r <= pwdata[`TBC_FLUSH_CONTROL_REG_DRAIN];
         end else if (state_r == ST_DISABLED) begin
            if (is_reg(paddr, `TBC_BUFFER_SIZE_REG)) begin
               if (pwdata[30:0] > `TBC_BUFFER_SIZE_MAX)
                  buffer_size_r <= `TBC_BUFFER_SIZE_MAX;
               else
                  buffer_size_r <= pwdata[30:0];
            end else if (is_reg(paddr, `TBC_MODE_REG))
               mode_r <= pwdata[1:0];
            else if (is_reg(paddr, `TBC_WATERMARK_REG))
               watermark_r <= pwdata[`TBC_LEVEL_BITS-1:0];
            else if (is_reg(paddr, `TBC_BASE_LO_REG))
               // base taken on a 4KB boundary
               base_r <= {pwdata[31:`TBC_BASE_ALIGN_BITS],
                          {`TBC_BASE_ALIGN_BITS{1'b0}}};
            else if (is_reg(paddr, `TBC_CONFIG_REG))
               cfg_r <= pwdata[`TBC_CFG_MSB:`TBC_CFG_LSB];
            else if (!is_reg(paddr, `TBC_STATUS_REG))
               pslverr <= 1'b1;
         end else if (!is_reg(paddr, `TBC_STATUS_REG))
            pslverr <= 1'b1;
      end
      if (apb_rd) begin
         prdata <= `TBC_ZERO32;
         if (is_reg(paddr, `TBC_CTL_REG))
            prdata[`TBC_CTL_CAPTURE_EN] <= capture_enable_r;
         else if (is_reg(paddr, `TBC_STATUS_REG)) begin
            // stopping looks like running: ready only when idle
            prdata[`TBC_STS_FULL]    <= full_r;
            prdata[`TBC_STS_READY]   <= (state_r == ST_DISABLED) |
                                        (state_r == ST_STOPPED);
            prdata[`TBC_STS_MEM_ERR] <= memory_error_flag_r;
         end else if (is_reg(paddr, `TBC_BUFFER_SIZE_REG))
            prdata[30:0] <= buffer_size_r;
         else if (is_reg(paddr, `TBC_MODE_REG))
            prdata[1:0] <= mode_r;
         else if (is_reg(paddr, `TBC_FILL_LEVEL_REG))
            prdata[`TBC_LEVEL_BITS-1:0] <= level_r;
         else if (is_reg(paddr, `TBC_WATERMARK_REG))
            prdata[`TBC_LEVEL_BITS-1:0] <= watermark_r;
         else if (is_reg(paddr, `TBC_BASE_LO_REG))
            prdata <= base_r;
         else if (is_reg(paddr, `TBC_CONFIG_REG))
            prdata[`TBC_CFG_MSB:`TBC_CFG_LSB] <= cfg_r;
         else if (is_reg(paddr, `TBC_FLUSH_CONTROL_REG)) begin
            prdata[`TBC_FLUSH_CONTROL_REG_STOP_ON_FL]   <= stop_on_flush_r;
            prdata[`TBC_FLUSH_CONTROL_REG_MANUAL_FLUSH] <= manual_flush_r;
            prdata[`TBC_FLUSH_CONTROL_REG_DRAIN]        <= drain_request_r;
         end else if (is_reg(paddr, `TBC_READ_DATA_REG))
            prdata <= empty ? `TBC_EMPTY_READ : head;
         else
            pslverr <= 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// trace memory and pointers
always @(posedge pclk) begin
   if (gclk_en && push)
      mem_r[wptr_r] <= atb_data;
end

always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      wptr_r    <= {`TBC_PTR_BITS{1'b0}};
      rptr_r    <= {`TBC_PTR_BITS{1'b0}};
      level_r   <= {`TBC_LEVEL_BITS{1'b0}};
      full_r    <= 1'b0;
      atb_ready <= 1'b0;
   end else if (gclk_en) begin
      // circular never stalls while capturing; fifo modes hold off when full unless the next state is disabling
      atb_ready <= capturing & (~fifo_md | ~is_full |
                   (state_nxt == ST_DISABLING));
      if (capture_enable_r ? state_r==ST_DISABLED : memory_error_flag_r) begin
         wptr_r  <= {`TBC_PTR_BITS{1'b0}};
         rptr_r  <= {`TBC_PTR_BITS{1'b0}};
         level_r <= {`TBC_LEVEL_BITS{1'b0}};
         full_r  <= 1'b0;
      end else begin
         if (push)
            wptr_r <= wptr_r + 1'b1;
         if (pop | ovr)
            rptr_r <= rptr_r + 1'b1;
         if (push & ~pop & ~ovr)
            level_r <= level_r + 1'b1;
         else if (pop & ~push)
            level_r <= level_r - 1'b1;
         if (push & is_full)
            full_r <= 1'b1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// outputs: drain, axi, stream, events, interrupt
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      drain_valid         <= 1'b0;
      drain_data          <= `TBC_ZERO32;
      awvalid             <= 1'b0;
      awaddr              <= `TBC_ZERO32;
      wvalid              <= 1'b0;
      wdata               <= `TBC_ZERO32;
      bready              <= 1'b0;
      arvalid             <= 1'b0;
      araddr              <= `TBC_ZERO32;
      tvalid              <= 1'b0;
      tdata               <= `TBC_ZERO32;
      tkeep               <= 4'h0;
      event_out           <= 3'h0;
      buffer_irq          <= 1'b0;
      outstanding_r       <= 6'h00;
      wr_offset_r         <= `TBC_ZERO32;
      memory_error_flag_r <= 1'b0;
      event_in_d_r        <= 2'h0;
   end else if (gclk_en) begin
      event_in_d_r <= event_in;
      if (drain_valid & drain_ready)
         drain_valid <= 1'b0;
      if (drn_go | hw_go) begin
         drain_valid <= 1'b1;
         drain_data  <= head;
      end
      bready  <= sysmem;
      arvalid <= 1'b0;
      araddr  <= `TBC_ZERO32;
      if (axi_done_aw)
         awvalid <= 1'b0;
      if (axi_done_w)
         wvalid <= 1'b0;
      if (axi_go) begin
         awvalid <= 1'b1;
         wvalid  <= 1'b1;
         wdata   <= head;
         awaddr  <= {base_r[31:`TBC_AXI_ALIGN_BITS] +
                     wr_offset_r[31:`TBC_AXI_ALIGN_BITS],
                     {`TBC_AXI_ALIGN_BITS{1'b0}}};
         wr_offset_r <= ((wr_offset_r[30:0] + 31'h0000_0008) >=
                         {buffer_size_r[28:0], 2'h0}) ?
                        `TBC_ZERO32 : wr_offset_r + 32'h0000_0008;
      end
      if (axi_go & ~(bvalid & bready))
         outstanding_r <= outstanding_r + 6'h01;
      else if (~axi_go & bvalid & bready)
         outstanding_r <= outstanding_r - 6'h01;
      // error sets win over software clearing the flag
      if (bvalid & bready & bresp[1])
         memory_error_flag_r <= 1'b1;
      else if (apb_wr & is_reg(paddr, `TBC_STATUS_REG) &
               ~pwdata[`TBC_STS_MEM_ERR])
         memory_error_flag_r <= 1'b0;
      if (tvalid & tready)
         tvalid <= 1'b0;
      if (str_go) begin
         tvalid <= 1'b1;
         tdata  <= head;
         tkeep  <= 4'hF;
      end
      event_out[0] <= (state_r == ST_STOPPED);
      event_out[1] <= full_r;
      event_out[2] <= manual_flush_r & capturing;
      buffer_irq   <= (sysmem | stream) &
                      (level_r >= watermark_r);
   end
end

endmodule // tbc_trace_buffer_controller

/* tbc_map.vh */
// register offsets, field positions, reset values and codes for the trace
// buffer controller; assumes a 32-bit apb register file
`ifndef TBC_MAP_VH
`define TBC_MAP_VH

// apb byte offsets
`define TBC_BUFFER_SIZE_REG   12'h004
`define TBC_STATUS_REG        12'h00C
`define TBC_READ_DATA_REG     12'h010
`define TBC_CTL_REG           12'h020
`define TBC_MODE_REG          12'h028
`define TBC_FILL_LEVEL_REG    12'h030
`define TBC_WATERMARK_REG     12'h034
`define TBC_BASE_LO_REG       12'h118
`define TBC_FLUSH_CONTROL_REG 12'h304
`define TBC_CONFIG_REG        12'h400

// field positions
`define TBC_CTL_CAPTURE_EN    0
`define TBC_STS_FULL          0
`define TBC_STS_READY         2
`define TBC_STS_MEM_ERR       5
`define TBC_FLUSH_CONTROL_REG_STOP_ON_FL   12
`define TBC_FLUSH_CONTROL_REG_MANUAL_FLUSH 6
`define TBC_FLUSH_CONTROL_REG_DRAIN        20
`define TBC_CFG_LSB           0
`define TBC_CFG_MSB           1

// configurations
`define TBC_CFG_SRAM_BUFFER   2'h0
`define TBC_CFG_SRAM_FIFO     2'h1
`define TBC_CFG_SYSTEM_MEMORY 2'h2
`define TBC_CFG_STREAM_OUT    2'h3

// modes
`define TBC_MODE_CIRCULAR     2'h0
`define TBC_MODE_SOFT_APB     2'h1
`define TBC_MODE_HARD_FIFO    2'h2
`define TBC_MODE_SOFT_DIRECT  2'h3

// sizes and resets
`define TBC_BUFFER_SIZE_MAX   31'h0400_0000
`define TBC_BUFFER_SIZE_RST   31'h0000_0400
`define TBC_BASE_ALIGN_BITS   12
`define TBC_AXI_ALIGN_BITS    3
`define TBC_MAX_OUTSTANDING   6'h20
`define TBC_ZERO32            32'h0000_0000
`define TBC_EMPTY_READ        32'hFFFF_FFFF
`define TBC_MEM_DEPTH         16
`define TBC_PTR_BITS          4
`define TBC_LEVEL_BITS        5
`define TBC_LEVEL_FULL        5'h10

`endif

/* tbc_properties.sv */
// port checker for the trace buffer controller
// assumes one clock pclk and an async active-low presetn
`timescale 1ns/1ps
module tbc_properties (
   // clock, reset, enables
   input wire        pclk,
   input wire        presetn,
   input wire        clk_en,
   input wire        dft_cg_en,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pready,
   input wire        pslverr,
   // axi
   input wire        awvalid,
   input wire [31:0] awaddr,
   input wire        awready,
   input wire        bvalid,
   input wire        bready,
   input wire        arvalid,
   // stream and drain
   input wire        tvalid,
   input wire [31:0] tdata,
   input wire [3:0]  tkeep,
   input wire        tready,
   input wire        drain_valid,
   input wire [31:0] drain_data,
   input wire        drain_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   integer out_cnt_r;
   // counts address handshakes not yet answered on the b channel
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         out_cnt_r <= 0;
      else
         out_cnt_r <= out_cnt_r + (awvalid && awready ? 1 : 0)
                      - (bvalid && bready ? 1 : 0);
   end
   ////////////////////////////////////////////////////////////////////////
   property p_no_read; arvalid == 1'b0; endproperty
   a_no_read: assert property (p_no_read)
      else $error("read request issued");
   property p_outstanding; out_cnt_r <= 32; endproperty
   a_outstanding: assert property (p_outstanding)
      else $error("more than 32 writes in flight");
   property p_align; awvalid |-> awaddr[2:0] == 3'h0; endproperty
   a_align: assert property (p_align)
      else $error("unaligned write address");
   property p_answer;
      psel && penable && !pready && (clk_en || dft_cg_en) |=> pready;
   endproperty
   a_answer: assert property (p_answer)
      else $error("apb access not answered");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse)
      else $error("pready longer than one cycle");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err)
      else $error("pslverr without pready");
   property p_aw_hold; awvalid && !awready |=> awvalid && $stable(awaddr);
   endproperty
   a_aw_hold: assert property (p_aw_hold)
      else $error("write address dropped while stalled");
   property p_t_hold; tvalid && !tready |=> tvalid && $stable(tdata);
   endproperty
   a_t_hold: assert property (p_t_hold)
      else $error("stream beat dropped while stalled");
   property p_t_data; tvalid |-> tkeep != 4'h0; endproperty
   a_t_data: assert property (p_t_data)
      else $error("stream beat without data bytes");
   property p_d_hold;
      drain_valid && !drain_ready |=> drain_valid && $stable(drain_data);
   endproperty
   a_d_hold: assert property (p_d_hold)
      else $error("drain beat dropped while stalled");
endmodule // tbc_properties
bind tbc_trace_buffer_controller tbc_properties u_props (.pclk, .presetn,
   .clk_en, .dft_cg_en, .psel, .penable, .pready, .pslverr, .awvalid,
   .awaddr, .awready, .bvalid, .bready, .arvalid, .tvalid, .tdata, .tkeep,
   .tready, .drain_valid, .drain_data, .drain_ready);

/* tbc_far_end.sv */
// far side: axi write slave, stream sink and drain sink with random stalls
// assumes the controller holds each valid until its ready
`timescale 1ns/1ps
module tbc_far_end (
   // clock, reset, fault select
   input wire       pclk,
   input wire       presetn,
   input wire       err_mode,
   // axi write slave
   input wire       awvalid,
   output reg       awready,
   input wire       wvalid,
   output reg       wready,
   output reg       bvalid,
   output reg [1:0] bresp,
   input wire       bready,
   // sinks
   input wire       tvalid,
   output reg       tready,
   input wire       drain_valid,
   output reg       drain_ready
);
   integer    pend;
   integer    seed = 32'h6a77_ec0b;
   reg [31:0] rnd;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {awready, wready, tready, drain_ready, bvalid} <= 5'h00;
         bresp <= 2'h0;
         pend = 0;
      end else begin
         rnd = $random(seed);
         // readies drop at random to stall every channel
         {awready, wready, tready, drain_ready} <= rnd[3:0];
         if (wvalid && wready)
            pend = pend + 1;
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            bresp <= ~bresp;
         end else if (!bvalid && pend > 0) begin
            bvalid <= 1'b1;
            bresp <= err_mode ? 2'h2 : 2'h0;
            pend = pend - 1;
         end else if (!bvalid)
            bresp <= ~bresp;
      end
   end
endmodule // tbc_far_end

/* tb_top.sv */
// self-checking bench: apb master, atb source, queue model of trace order
// assumes one wait state on apb and in-order trace through every sink
`timescale 1ns/1ps
`include "tbc_map.vh"
module tb_top;
   reg        pclk = 0, presetn = 0, clk_en = 1, dft_cg_en = 0;
   reg        psel = 0, penable = 0, pwrite = 0, atb_valid = 0;
   reg        auth_enable = 1, err_mode = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, atb_data = 0, rd;
   reg [1:0]  event_in = 0;
   wire [31:0] prdata, drain_data, awaddr, wdata, araddr, tdata;
   wire [3:0]  tkeep;
   wire [2:0]  event_out;
   wire [1:0]  bresp;
   wire pready, pslverr, atb_ready, drain_valid, drain_ready, awvalid;
   wire awready, wvalid, wready, bvalid, bready, arvalid, tvalid, tready;
   wire buffer_irq;
   integer fails = 0, samples_checked = 0, cyc = 0, seed = 32'h6a77_ec0b;
   integer m, n;
   reg [31:0] q_exp[$];
   tbc_trace_buffer_controller DUT (.pclk, .presetn, .clk_en, .dft_cg_en,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .atb_valid, .atb_data, .atb_ready, .drain_valid, .drain_data,
      .drain_ready, .awvalid, .awaddr, .awready, .wvalid, .wdata, .wready,
      .bvalid, .bresp, .bready, .arvalid, .araddr, .tvalid, .tdata, .tkeep,
      .tready, .event_in, .event_out, .buffer_irq, .auth_enable);
   tbc_far_end u_far (.pclk, .presetn, .err_mode, .awvalid, .awready,
      .wvalid, .wready, .bvalid, .bresp, .bready, .tvalid, .tready,
      .drain_valid, .drain_ready);
   always #10 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d mismatches %0d", samples_checked, fails);
         if (fails == 0 && samples_checked > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task apb(input w, input [11:0] a, input [31:0] d, input e);
      integer k;
      begin
         k = 0;
         {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1 && k < 40) begin
            @(posedge pclk);
            k = k + 1;
         end
         rd = prdata;
         chk({31'h0, pslverr}, {31'h0, e});
         if (k == 40)
            fails = fails + 1;
         {psel, penable} <= 2'b00;
         @(posedge pclk);
      end
   endtask
   task push(input integer cnt);
      integer i, k;
      begin
         for (i = 0; i < cnt; i = i + 1) begin
            atb_valid <= 1'b1;
            atb_data <= $random(seed);
            k = 0;
            @(posedge pclk);
            while (atb_ready !== 1'b1 && k < 100) begin
               @(posedge pclk);
               k = k + 1;
            end
            q_exp.push_back(atb_data);
         end
         atb_valid <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task wait_stop(input v);
      begin
         for (n = 0; n < 300 && event_out[0] !== v; n = n + 1)
            @(posedge pclk);
         chk({31'h0, event_out[0]}, {31'h0, v});
      end
   endtask
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         fails = fails + 1;
         finish_test;
      end
      if (presetn && (wvalid && wready || tvalid && tready
                      || drain_valid && drain_ready)) begin
         if (q_exp.size() == 0)
            chk(32'h0, 32'h1);
         else
            chk(wvalid ? wdata : tvalid ? tdata : drain_data,
                q_exp.pop_front());
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, `TBC_BUFFER_SIZE_REG, 0, 0);
      chk(rd, {1'b0, `TBC_BUFFER_SIZE_RST});
      apb(0, `TBC_STATUS_REG, 0, 0);
      chk(rd & 32'h0000_0024, 32'h0000_0004);
      apb(0, 12'hFF0, 0, 1);
      apb(1, `TBC_BUFFER_SIZE_REG, 32'h7FFF_FFFF, 0);
      apb(0, `TBC_BUFFER_SIZE_REG, 0, 0);
      chk(rd, {1'b0, `TBC_BUFFER_SIZE_MAX});
      for (m = 3; m >= 0; m = m - 1)
         apb(1, `TBC_MODE_REG, m, 0);
      $display("test registers done");
      for (m = 2; m < 4; m = m + 1) begin
         apb(1, `TBC_CONFIG_REG, m, 0);
         apb(1, `TBC_WATERMARK_REG, 2, 0);
         apb(1, `TBC_BASE_LO_REG, 32'h0001_0000, 0);
         apb(1, `TBC_CTL_REG, 1, 0);
         apb(1, `TBC_WATERMARK_REG, 3, 1);
         auth_enable <= 1'b0;
         push(1);
         if (m == 2)
            q_exp.delete();
         auth_enable <= 1'b1;
         push(4);
         if (m == 3)
            event_in <= 2'b10;
         else
            apb(1, `TBC_FLUSH_CONTROL_REG, 32'h0000_1040, 0);
         wait_stop(1);
         chk(q_exp.size(), 0);
         event_in <= 2'b00;
         apb(0, `TBC_FILL_LEVEL_REG, 0, 0);
         chk({31'h0, buffer_irq}, {31'h0, rd >= 2});
         apb(1, `TBC_CTL_REG, 0, 0);
         wait_stop(0);
         $display("test capture config %0d done", m);
      end
      err_mode <= 1'b1;
      apb(1, `TBC_CONFIG_REG, 2, 0);
      apb(1, `TBC_CTL_REG, 1, 0);
      push(2);
      rd = 0;
      for (m = 0; m < 20 && rd[5] !== 1'b1; m = m + 1)
         apb(0, `TBC_STATUS_REG, 0, 0);
      chk(rd & 32'h0000_0020, 32'h0000_0020);
      apb(1, `TBC_CTL_REG, 0, 0);
      wait_stop(0);
      apb(1, `TBC_STATUS_REG, 0, 0);
      apb(0, `TBC_STATUS_REG, 0, 0);
      chk(rd & 32'h0000_0024, 32'h0000_0004);
      err_mode <= 1'b0;
      q_exp.delete();
      $display("test memory error done");
      apb(1, `TBC_CONFIG_REG, 1, 0);
      apb(1, `TBC_CTL_REG, 1, 0);
      push(5);
      apb(1, `TBC_FLUSH_CONTROL_REG, 32'h0000_1040, 0);
      wait_stop(1);
      apb(1, `TBC_FLUSH_CONTROL_REG, 32'h0010_1000, 0);
      for (m = 0; m < 300 && q_exp.size() != 0; m = m + 1)
         @(posedge pclk);
      chk(q_exp.size(), 0);
      wait_stop(1);
      apb(1, `TBC_CTL_REG, 0, 0);
      $display("test drain done");
      clk_en <= 1'b0;
      dft_cg_en <= 1'b1;
      apb(0, `TBC_BUFFER_SIZE_REG, 0, 0);
      chk(rd, {1'b0, `TBC_BUFFER_SIZE_MAX});
      $display("test clock gate override done");
      finish_test;
   end
endmodule // tb_top
